/* design/fps_defines.svh */
// Holds the numeric constants of the flash program store control block.
// Assumes inclusion by bare name from the package and from the design module.
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH
// ****************************************************************
// Register addresses on the special function register port
// ****************************************************************
`define FPS_PSC_ADDR 8'h8F
`define FPS_KEY_ADDR 8'hB7
`define FPS_RSS_ADDR 8'hEF
// ****************************************************************
// Field positions and values
// ****************************************************************
`define FPS_PSC_WE_BIT 0
`define FPS_PSC_EE_BIT 1
`define FPS_RSS_POR_BIT 0
`define FPS_RSS_MRE_BIT 1
`define FPS_RSS_FERR_BIT 6
`define FPS_RSS_MEN_BIT 7
`define FPS_PSC_RESET 2'h0
`define FPS_KEY_FIRST 8'hA5
`define FPS_KEY_SECOND 8'hF1
`define FPS_PAGE_BITS 9
`define FPS_ERASE_BYTE 8'hFF
`define FPS_ADDR_W 14
`endif

/* design/fps_pkg.sv */
// Holds the types shared by the flash program store control block.
// Assumes the defines header is on the include path.
`include "fps_defines.svh"
`default_nettype none
package fps_pkg;
   // One-hot states of the key lock.
   typedef enum logic [3:0] {
      FPS_LOCKED   = 4'h1,
      FPS_FIRST    = 4'h2,
      FPS_UNLOCKED = 4'h4,
      FPS_DISABLED = 4'h8
   } fps_key_t;
   // One-hot states of the operation sequencer.
   typedef enum logic [1:0] {
      FPS_IDLE = 2'h1,
      FPS_BUSY = 2'h2
   } fps_op_t;
   // External-memory write request from the core.
   typedef struct packed {
      logic [`FPS_ADDR_W-1:0] addr;
      logic [7:0] data;
   } fps_xwr_t;
   // Command to the flash array.
   typedef struct packed {
      logic prog;
      logic erase;
      logic [`FPS_ADDR_W-1:0] addr;
      logic [7:0] data;
   } fps_cmd_t;
endpackage
`default_nettype wire

/* design/fps_flash_ctrl.sv */
// Holds the flash program store controller: control and key registers, the
// supply interlock, the operation sequencer and the error reset request.
// Assumes a core on sys_clk issuing register and external-memory writes,
// and a flash array that answers each command with a one-cycle done pulse.
`include "fps_defines.svh"
`default_nettype none
module fps_flash_ctrl (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic por_n,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic xwr_valid,
   input wire fps_pkg::fps_xwr_t xwr_req,
   output logic xram_wr,
   output fps_pkg::fps_xwr_t xram_req,
   output fps_pkg::fps_cmd_t flash_cmd,
   input wire logic flash_done,
   output logic irq_defer,
   output logic flash_error_device_reset
);
   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic [1:0] rst_sync_reg;
   logic [1:0] por_sync_reg;
   logic rst_n;
   logic por_ok;

   // Both resets assert at once and release through two flops.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   always_ff @(posedge sys_clk or negedge por_n) begin
      if (!por_n) begin
         por_sync_reg <= 2'h0;
      end else begin
         por_sync_reg <= {por_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];
   assign por_ok = por_sync_reg[1];

   // ****************************************************************
   // Decode helpers
   // ****************************************************************
   // Lock state code as software reads it.
   function automatic logic [1:0] key_code(input fps_pkg::fps_key_t s);
      case (s)
         fps_pkg::FPS_FIRST: key_code = 2'h1;
         fps_pkg::FPS_UNLOCKED: key_code = 2'h2;
         fps_pkg::FPS_DISABLED: key_code = 2'h3;
         default: key_code = 2'h0;
      endcase
   endfunction

   // ****************************************************************
   // Registers and sequencer
   // ****************************************************************
   logic we_reg, we_next, ee_reg, ee_next;
   logic men_reg, men_next, mre_reg, mre_next;
   fps_pkg::fps_key_t key_reg, key_next;
   fps_pkg::fps_op_t op_reg, op_next;
   fps_pkg::fps_cmd_t cmd_next;
   logic xram_wr_next, flash_error_device_reset_next, started_reg;
   logic [7:0] rdata_next;
   fps_pkg::fps_xwr_t xram_req_next;
   logic wr_psc, wr_key, wr_rss, take, monitor_ok;
   logic flash_error_device_reset_pend_reg, flash_error_device_reset_pend_next, ferr_reg, ferr_next;
   logic por_fresh_reg, por_fresh_next, por_flag_reg, por_flag_next;

   assign wr_psc = sfr_wr && (sfr_addr == `FPS_PSC_ADDR);
   assign wr_key = sfr_wr && (sfr_addr == `FPS_KEY_ADDR);
   assign wr_rss = sfr_wr && (sfr_addr == `FPS_RSS_ADDR);
   // A request arriving while the array is busy is dropped; the core stalls.
   assign take = xwr_valid && (op_reg == fps_pkg::FPS_IDLE);
   assign monitor_ok = men_reg && mre_reg;

   // Next values for control bits, key lock, sequencer and outputs.
   always_comb begin
      we_next = we_reg;
      ee_next = ee_reg;
      men_next = men_reg;
      mre_next = mre_reg;
      key_next = key_reg;
      op_next = op_reg;
      cmd_next = '0;
      xram_wr_next = 1'b0;
      xram_req_next = xram_req;
      flash_error_device_reset_next = 1'b0;
      rdata_next = sfr_rdata;
      if (wr_psc) begin
         we_next = sfr_wdata[`FPS_PSC_WE_BIT];
         ee_next = sfr_wdata[`FPS_PSC_EE_BIT];
      end
      if (wr_rss) begin
         men_next = sfr_wdata[`FPS_RSS_MEN_BIT];
         mre_next = sfr_wdata[`FPS_RSS_MRE_BIT];
      end
      // Any key write other than the expected next key disables until reset; a flash start in the same cycle wins and relocks to FPS_LOCKED.
      if (wr_key) begin
         unique case (key_reg)
            fps_pkg::FPS_LOCKED:
               key_next = (sfr_wdata == `FPS_KEY_FIRST) ? fps_pkg::FPS_FIRST :
                          fps_pkg::FPS_DISABLED;
            fps_pkg::FPS_FIRST:
               key_next = (sfr_wdata == `FPS_KEY_SECOND) ? fps_pkg::FPS_UNLOCKED :
                          fps_pkg::FPS_DISABLED;
            fps_pkg::FPS_UNLOCKED: key_next = fps_pkg::FPS_DISABLED;
            fps_pkg::FPS_DISABLED: key_next = fps_pkg::FPS_DISABLED;
         endcase
      end
      unique case (op_reg)
         fps_pkg::FPS_IDLE: begin
            if (take && !we_reg) begin
               xram_wr_next = 1'b1;
               xram_req_next = xwr_req;
            end else if (take && !monitor_ok) begin
               flash_error_device_reset_next = 1'b1;
            end else if (take && key_reg == fps_pkg::FPS_UNLOCKED) begin
               cmd_next.erase = ee_reg;
               cmd_next.prog = !ee_reg;
               cmd_next.addr = xwr_req.addr;
               cmd_next.data = xwr_req.data;
               if (ee_reg) begin
                  // The page base is sent and the data byte is replaced.
                  cmd_next.addr[`FPS_PAGE_BITS-1:0] = '0;
                  cmd_next.data = `FPS_ERASE_BYTE;
               end
               key_next = fps_pkg::FPS_LOCKED;
               op_next = fps_pkg::FPS_BUSY;
            end else if (take) begin
               key_next = fps_pkg::FPS_DISABLED;
            end
         end
         fps_pkg::FPS_BUSY: begin
            if (flash_done) begin
               op_next = fps_pkg::FPS_IDLE;
            end
         end
      endcase
      if (sfr_rd) begin
         unique case (sfr_addr)
            `FPS_PSC_ADDR: rdata_next = {6'h00, ee_reg, we_reg};
            `FPS_KEY_ADDR: rdata_next = {6'h00, key_code(key_reg)};
            `FPS_RSS_ADDR: rdata_next = {men_reg, ferr_reg, 4'h0, mre_reg, por_flag_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // Registers of the block; the monitor enables come up set.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         {ee_reg, we_reg} <= `FPS_PSC_RESET;
         men_reg <= 1'b1;
         mre_reg <= 1'b1;
         key_reg <= fps_pkg::FPS_LOCKED;
         op_reg <= fps_pkg::FPS_IDLE;
         flash_cmd <= '0;
         xram_wr <= 1'b0;
         xram_req <= '0;
         flash_error_device_reset <= 1'b0;
         irq_defer <= 1'b0;
         sfr_rdata <= 8'h00;
         started_reg <= 1'b0;
      end else begin
         we_reg <= we_next;
         ee_reg <= ee_next;
         men_reg <= men_next;
         mre_reg <= mre_next;
         key_reg <= key_next;
         op_reg <= op_next;
         flash_cmd <= cmd_next;
         xram_wr <= xram_wr_next;
         xram_req <= xram_req_next;
         flash_error_device_reset <= flash_error_device_reset_next;
         irq_defer <= (op_next == fps_pkg::FPS_BUSY);
         sfr_rdata <= rdata_next;
         started_reg <= 1'b1;
      end
   end

   // ****************************************************************
   // Reset cause flags
   // ****************************************************************
   // These survive a device reset, but each release reloads both flags. The cause
   // is latched before the reset and moved to the flag on the first cycle
   // after release, which is why the flag lags release by one cycle.

   always_comb begin
      flash_error_device_reset_pend_next = flash_error_device_reset_pend_reg || flash_error_device_reset_next;
      ferr_next = ferr_reg;
      por_fresh_next = por_fresh_reg;
      por_flag_next = por_flag_reg;
      if (!started_reg && rst_n) begin
         ferr_next = flash_error_device_reset_pend_reg;
         flash_error_device_reset_pend_next = flash_error_device_reset_next; // A new error request wins over the clear.
         por_flag_next = por_fresh_reg;
         por_fresh_next = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge por_ok) begin
      if (!por_ok) begin
         flash_error_device_reset_pend_reg <= 1'b0;
         ferr_reg <= 1'b0;
         por_fresh_reg <= 1'b1;
         por_flag_reg <= 1'b0;
      end else begin
         flash_error_device_reset_pend_reg <= flash_error_device_reset_pend_next;
         ferr_reg <= ferr_next;
         por_fresh_reg <= por_fresh_next;
         por_flag_reg <= por_flag_next;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_key_first;
      wr_key && !take && sfr_wdata == `FPS_KEY_FIRST && key_reg == fps_pkg::FPS_LOCKED;
   endsequence
   sequence s_key_second;
      wr_key && !take && sfr_wdata == `FPS_KEY_SECOND;
   endsequence

   chk_supply_interlock: assert property (
      (take && we_reg && !monitor_ok) |=> (flash_error_device_reset && !flash_cmd.prog
         && !flash_cmd.erase)) else $error("flash changed without supply interlock");
   chk_monitor_default: assert property (
      $rose(rst_n) |-> (men_reg && mre_reg)) else $error("monitor enables not set after reset");
   chk_irq_start: assert property (
      (flash_cmd.prog || flash_cmd.erase) |-> irq_defer)
      else $error("interrupts not deferred at flash start");
   chk_irq_hold: assert property (
      (irq_defer && !flash_done) |=> irq_defer)
      else $error("interrupts released before flash done");
   chk_reserved_zero: assert property (
      (sfr_rd && sfr_addr == `FPS_PSC_ADDR) |=> (sfr_rdata[7:2] == 6'h00))
      else $error("reserved control bits not zero");
   chk_page_erase: assert property (
      (take && we_reg && ee_reg && monitor_ok && key_reg == fps_pkg::FPS_UNLOCKED)
      |=> (flash_cmd.erase && !flash_cmd.prog && flash_cmd.data == `FPS_ERASE_BYTE))
      else $error("page erase not issued");
   chk_byte_prog: assert property (
      (take && we_reg && !ee_reg && monitor_ok && key_reg == fps_pkg::FPS_UNLOCKED)
      |=> (flash_cmd.prog && flash_cmd.addr == $past(xwr_req.addr)))
      else $error("byte program not issued at address");
   chk_xram_steer: assert property (
      (take && !we_reg) |=> (xram_wr && !flash_cmd.prog && !flash_cmd.erase))
      else $error("write not steered to data memory");
   chk_key_unlock: assert property (
      s_key_first ##1 s_key_second |=> (key_code(key_reg) == 2'h2 && !flash_cmd.prog))
      else $error("key pair did not unlock");
   chk_key_expire: assert property (
      (flash_cmd.prog || flash_cmd.erase) |-> (key_reg == fps_pkg::FPS_LOCKED))
      else $error("unlock outlived one operation");
   chk_key_readback: assert property (
      (sfr_rd && sfr_addr == `FPS_KEY_ADDR && !wr_key && !take)
      |=> (sfr_rdata == {6'h00, key_code($past(key_reg))})) else $error("key state misread");
   chk_page_align: assert property (
      flash_cmd.erase |-> (flash_cmd.addr[`FPS_PAGE_BITS-1:0] == '0))
      else $error("erase not page aligned");
   chk_error_latched: assert property (
      flash_error_device_reset |-> flash_error_device_reset_pend_reg) else $error("error cause not latched");
endmodule // fps_flash_ctrl
`default_nettype wire

/* verification/fps_flash_model.sv */
// Holds a behavioural model of the flash array behind the program store control.
// Assumes one-cycle prog or erase pulses on flash_cmd and a shared sys_clk.
`default_nettype none
module fps_flash_model (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire fps_pkg::fps_cmd_t flash_cmd,
   input wire logic [3:0] lat,
   output logic flash_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt_reg;
   logic busy_reg;
   // ****************************************************************
   // Operation timer
   // ****************************************************************
   // A command starts a wait of lat cycles, then one done pulse ends it.
   // The latency input lets the bench try a prompt and a slow array.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= 4'h0;
         busy_reg <= 1'b0;
         flash_done <= 1'b0;
      end else begin
         flash_done <= 1'b0;
         if (flash_cmd.prog || flash_cmd.erase) begin
            busy_reg <= 1'b1;
            cnt_reg <= lat;
         end else if (busy_reg) begin
            if (cnt_reg == 4'h0) begin
               flash_done <= 1'b1;
               busy_reg <= 1'b0;
            end else begin
               cnt_reg <= cnt_reg - 4'h1;
            end
         end
      end
   end
endmodule // fps_flash_model
`default_nettype wire

/* verification/flash_program_store_control_tb_top.sv */
// Holds the self-checking bench of the flash program store controller.
// Assumes the design package and the flash model are compiled before it.
`default_nettype none
module flash_program_store_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, nrst = 1'b0, por_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, rd;
   logic xwr_valid = 1'b0, xram_wr, flash_done, irq_defer, flash_error_device_reset;
   logic [3:0] lat = 4'h0;
   fps_pkg::fps_xwr_t xwr_req = '0, xram_req;
   fps_pkg::fps_cmd_t flash_cmd;
   int n_mismatch = 0, comparisons = 0, cycles = 0;
   fps_flash_ctrl fps_flash_ctrl_inst (.sys_clk(sys_clk), .nrst(nrst), .por_n(por_n),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .xwr_valid(xwr_valid), .xwr_req(xwr_req), .xram_wr(xram_wr),
      .xram_req(xram_req), .flash_cmd(flash_cmd), .flash_done(flash_done),
      .irq_defer(irq_defer), .flash_error_device_reset(flash_error_device_reset));
   fps_flash_model fps_flash_model_inst (.sys_clk(sys_clk), .nrst(nrst),
      .flash_cmd(flash_cmd), .lat(lat), .flash_done(flash_done));
   // ****************************************************************
   // Clock and timeout
   // ****************************************************************
   // A 4 ns clock; the ceiling is far above the hundred or so cycles the tests need.
   // One steady clock stands for the internal oscillator during all flash work.
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   // ****************************************************************
   // Access tasks
   // ****************************************************************
   // Strobes rise 1 ns after an edge and drop 1 ns after the taking edge.
   task automatic sw(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk); #1;
      sfr_wr = 1'b1; sfr_addr = a; sfr_wdata = d;
      @(posedge sys_clk); #1;
      sfr_wr = 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Read data is registered at the taking edge, so it is settled 1 ns later.
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk); #1;
      sfr_rd = 1'b1; sfr_addr = a;
      @(posedge sys_clk); #1;
      sfr_rd = 1'b0;
      chk(32'(sfr_rdata), 32'(exp));
   endtask
   task automatic xw(input logic [13:0] a, input logic [7:0] d);
      @(posedge sys_clk); #1;
      xwr_valid = 1'b1; xwr_req = '{addr: a, data: d};
      @(posedge sys_clk); #1;
      xwr_valid = 1'b0;
   endtask
   // Interrupts stay deferred until the array finishes, then are released.
   task automatic wait_done();
      int i;
      for (i = 0; i < 20 && flash_done !== 1'b1; i++) begin
         chk(32'(irq_defer), 32'h1);
         @(posedge sys_clk); #1;
      end
      chk(32'(flash_done), 32'h1);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(32'(irq_defer), 32'h0);
   endtask
   task automatic unlock();
      sw(8'hB7, 8'hA5);
      rchk(8'hB7, 8'h01);
      sw(8'hB7, 8'hF1);
      rchk(8'hB7, 8'h02);
   endtask
   // Both keys on consecutive edges, with the strobe held high between them.
   task automatic unlock_fast();
      @(posedge sys_clk);
      #1;
      sfr_wr = 1'b1;
      sfr_addr = 8'hB7;
      sfr_wdata = 8'hA5;
      @(posedge sys_clk);
      #1;
      sfr_wdata = 8'hF1;
      @(posedge sys_clk);
      #1;
      sfr_wr = 1'b0;
   endtask
   // A plain device reset; the power-on input stays released.
   task automatic dev_reset();
      @(posedge sys_clk); #1;
      nrst = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      repeat (5) @(posedge sys_clk);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (10) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      por_n = 1'b1;
      repeat (5) @(posedge sys_clk);
      // Reset values, loose control bits and an unmapped place.
      rchk(8'h8F, 8'h00);
      rchk(8'hB7, 8'h00);
      rchk(8'hEF, 8'h83);
      sw(8'h8F, 8'hFE);
      rchk(8'h8F, 8'h02);
      sw(8'h10, 8'h5A);
      rchk(8'h10, 8'h00);
      // Erase enable alone leaves external writes in data memory.
      xw(14'h1234, 8'h3C);
      chk({31'h0, xram_wr}, 32'h1);
      chk(32'(xram_req), 32'({14'h1234, 8'h3C}));
      chk(32'(flash_cmd), 32'h0);
      // Page erase, prompt array; firmware refreshes the monitor first.
      // The bench raises no interrupt while write enable is set.
      sw(8'h8F, 8'h03);
      sw(8'hEF, 8'h83);
      unlock();
      xw(14'h0234, 8'h12);
      chk(32'(flash_cmd), 32'({1'b0, 1'b1, 14'h0200, 8'hFF}));
      chk({31'h0, xram_wr}, 32'h0);
      rchk(8'hB7, 8'h00);
      wait_done();
      // Program a byte of the erased page with a slow array.
      lat = 4'h6;
      sw(8'h8F, 8'h01);
      unlock();
      xw(14'h0235, 8'hA7);
      chk(32'(flash_cmd), 32'({1'b1, 1'b0, 14'h0235, 8'hA7}));
      wait_done();
      // An operation while locked is refused and disables the keys.
      xw(14'h0236, 8'h00);
      chk(32'(flash_cmd), 32'h0);
      rchk(8'hB7, 8'h03);
      // A wrong first key disables too; a plain reset clears it.
      dev_reset();
      rchk(8'hEF, 8'h82);
      sw(8'hB7, 8'h11);
      rchk(8'hB7, 8'h03);
      dev_reset();
      // Monitor off: a flash write asks for an error reset instead.
      sw(8'hEF, 8'h01);
      sw(8'h8F, 8'h01);
      unlock_fast();
      rchk(8'hB7, 8'h02);
      rchk(8'h8F, 8'h01);
      xw(14'h0300, 8'h00);
      chk({31'h0, flash_error_device_reset}, 32'h1);
      chk(32'(flash_cmd), 32'h0);
      dev_reset();
      rchk(8'hEF, 8'hC2);
      end_of_test();
   end
endmodule // flash_program_store_control_tb_top
`default_nettype wire
